// File: hdl/chps_clk_gen.sv
// card clock generator: internal clock stabilisation and divided, gated card clock
`timescale 1ns/10ps
module chps_clk_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control and result
  chps_clk_if.gen clk_ctl
);
  logic [chps_pkg::STABLE_CNT_W-1:0] stab_cnt_q;
  logic stable_q;
  logic [chps_pkg::DIV_W-1:0] div_cnt_q;
  logic [chps_pkg::DIV_W-1:0] half_period;
  logic card_clk_q;
  logic run;
  logic tick;

  // ==========================================================
  // internal clock stable after a fixed settling time
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stab_cnt_q <= '0;
      stable_q <= 1'b0;
    end else if (!clk_ctl.int_clk_en) begin
      stab_cnt_q <= '0;
      stable_q <= 1'b0;
    end else if (stab_cnt_q == chps_pkg::STABLE_CNT_W'(chps_pkg::CLK_STABLE_CYC - 1)) begin
      stable_q <= 1'b1;
    end else begin
      stab_cnt_q <= stab_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // divided clock: ref / (2 * divisor); divisor 0 behaves as 1 since the card clock is a flop output
  assign half_period = (clk_ctl.card_clk_divisor == '0) ? chps_pkg::DIV_W'(1) : clk_ctl.card_clk_divisor;
  assign run = clk_ctl.int_clk_en && stable_q && clk_ctl.card_clk_output_on;
  assign tick = (div_cnt_q == half_period - 1'b1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
      card_clk_q <= 1'b0;
    end else if (run || card_clk_q) begin
      // a stop request lets the high phase finish, so the card never sees a runt pulse
      if (tick) begin
        div_cnt_q <= '0;
        card_clk_q <= ~card_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
    end else begin
      div_cnt_q <= '0;
      card_clk_q <= 1'b0;
    end
  end

  assign clk_ctl.int_clk_stable = stable_q;
  assign clk_ctl.card_clk = card_clk_q;
endmodule

// File: hdl/chps_clk_if.sv
// signals between the register side and the card clock generator
`timescale 1ns/10ps
interface chps_clk_if;
  logic int_clk_en;
  logic card_clk_output_on;
  logic [chps_pkg::DIV_W-1:0] card_clk_divisor;
  logic int_clk_stable;
  logic card_clk;

  modport ctrl (
    output int_clk_en,
    output card_clk_output_on,
    output card_clk_divisor,
    input int_clk_stable,
    input card_clk
  );
  modport gen (
    input int_clk_en,
    input card_clk_output_on,
    input card_clk_divisor,
    output int_clk_stable,
    output card_clk
  );
endinterface

// File: hdl/chps_pkg.sv
// constants, register map and field layout of the card host clock and power setup block
// ==========================================================
// Behaviour
// - insertion and removal status bits clear when software writes 1 to them
// - present-state bit shows card presence; software powers and clocks only while it is 1
// - capability field reports base clock frequency; zero means obtain it elsewhere
// - internal-clock-stable flag rises after enabling; software polls it before card clock on
// - writing 1 to card clock output enable starts the divided card clock
// - writing 0 to card clock output enable stops the card clock
// - width control bit selects 4-bit mode when 1, 1-bit mode when 0
// - capability fields report timeout clock frequency and unit; zero means obtain elsewhere
package chps_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_PRESENT = 8'h00;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h04;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h08;
  localparam logic [7:0] OFS_HOST_CTRL = 8'h0c;
  localparam logic [7:0] OFS_TMO_CTRL = 8'h10;
  localparam logic [7:0] OFS_INT_STS = 8'h14;
  localparam logic [7:0] OFS_INT_STS_EN = 8'h18;
  localparam logic [7:0] OFS_INT_SIG_EN = 8'h1c;
  localparam logic [7:0] OFS_CAPS = 8'h20;
  // ==========================================================
  // field positions
  localparam int PS_CARD_IN = 0;
  localparam int PS_CMD_BUSY = 1;
  localparam int PS_DATA_BUSY = 2;
  localparam int CC_INT_EN = 0;
  localparam int CC_STABLE = 1;
  localparam int CC_OUT_ON = 2;
  localparam int CC_DIV_LSB = 8;
  localparam int PC_POWER = 0;
  localparam int PC_VOLT_LSB = 1;
  localparam int HC_WIDTH4 = 1;
  localparam int IS_INSERT = 0;
  localparam int IS_REMOVE = 1;
  localparam int IS_CARD_INT = 2;
  localparam int IS_DATA_TMO = 3;
  localparam int CAP_TMO_LSB = 0;
  localparam int CAP_TMO_UNIT = 7;
  localparam int CAP_BASE_LSB = 8;
  localparam int CAP_VOLT_LSB = 24;
  // ==========================================================
  // widths and reset values
  localparam int DIV_W = 8;
  localparam int VOLT_W = 3;
  localparam int TMO_W = 4;
  localparam int CAPF_W = 6;
  localparam int NUM_EVT = 4;
  localparam int TMO_CNT_W = 28;
  localparam int TMO_BASE_EXP = 13;
  localparam logic [TMO_W-1:0] TMO_MAX_VAL = 4'he;
  localparam logic [NUM_EVT-1:0] INT_EN_RST = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h80;
  localparam logic [VOLT_W-1:0] VOLT_RST = 3'h0;
  localparam logic [TMO_W-1:0] TMO_RST = 4'h0;
  // ==========================================================
  // timing
  localparam int REF_PERIOD_NS = 100;
  localparam int CLK_STABLE_NS = 1000;
  localparam int CLK_STABLE_CYC = (CLK_STABLE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int STABLE_CNT_W = 4;
endpackage

// File: hdl/chps_top.sv
// card host clock, power, width, detect and data timeout setup block with an avalon-mm register slave
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module chps_top #(
  parameter logic [chps_pkg::CAPF_W-1:0] BASE_FREQ_MHZ = 6'd10,
  parameter logic [chps_pkg::CAPF_W-1:0] TMO_FREQ = 6'd10,
  parameter logic TMO_UNIT_MHZ = 1'b1,
  parameter logic [chps_pkg::VOLT_W-1:0] VOLT_SUPPORT = 3'h7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // card slot and transfer engine status
  input wire logic card_detect_n,
  input wire logic card_int_n,
  input wire logic cmd_line_busy,
  input wire logic data_line_busy,
  input wire logic data_active,
  // card bus controls
  output logic card_clk,
  output logic bus_power_on,
  output logic [chps_pkg::VOLT_W-1:0] bus_volt_sel,
  output logic bus_width4,
  output logic irq
);
  // ==========================================================
  // declarations
  chps_clk_if clk_if ();

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;
  logic int_clk_en_q;
  logic card_clk_output_on_q;
  logic [chps_pkg::DIV_W-1:0] card_clk_divisor_q;
  logic bus_power_on_q;
  logic [chps_pkg::VOLT_W-1:0] bus_volt_sel_q;
  logic width4_q;
  logic [chps_pkg::TMO_W-1:0] tmo_val_q;
  logic [chps_pkg::NUM_EVT-1:0] sts_q;
  logic [chps_pkg::NUM_EVT-1:0] sts_en_q;
  logic [chps_pkg::NUM_EVT-1:0] sig_en_q;
  logic [chps_pkg::NUM_EVT-1:0] evt_set;
  logic [chps_pkg::NUM_EVT-1:0] evt_clr;
  logic card_in_q;
  logic card_in_seen_q;
  logic [chps_pkg::TMO_CNT_W-1:0] tmo_cnt_q;
  logic tmo_hit_q;
  logic tmo_fire;
  logic irq_q;
  logic [31:0] caps;

  // ==========================================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic reg_hit(input logic [7:0] ofs);
    return wr_en && (avs_address == ofs);
  endfunction

  // timeout limit 2^(13+value), value above the largest legal code is held at that code
  function automatic logic [chps_pkg::TMO_CNT_W-1:0] tmo_limit(input logic [chps_pkg::TMO_W-1:0] v);
    logic [chps_pkg::TMO_W-1:0] vc;
    vc = (v > chps_pkg::TMO_MAX_VAL) ? chps_pkg::TMO_MAX_VAL : v;
    return chps_pkg::TMO_CNT_W'(1) << (chps_pkg::TMO_BASE_EXP + int'(vc));
  endfunction

  // ==========================================================
  // capability word, constant
  always_comb begin
    caps = '0;
    caps[chps_pkg::CAP_TMO_LSB +: chps_pkg::CAPF_W] = TMO_FREQ;
    caps[chps_pkg::CAP_TMO_UNIT] = TMO_UNIT_MHZ;
    caps[chps_pkg::CAP_BASE_LSB +: chps_pkg::CAPF_W] = BASE_FREQ_MHZ;
    caps[chps_pkg::CAP_VOLT_LSB +: chps_pkg::VOLT_W] = VOLT_SUPPORT;
  end

  // ==========================================================
  // avalon handshake: one wait state, read data captured as the request is first seen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  assign wr_en = avs_write && ack_q;

  always_comb begin
    rdata_d = '0;
    unique case (avs_address)
      chps_pkg::OFS_PRESENT: begin
        rdata_d[chps_pkg::PS_CARD_IN] = card_in_q;
        rdata_d[chps_pkg::PS_CMD_BUSY] = cmd_line_busy;
        rdata_d[chps_pkg::PS_DATA_BUSY] = data_line_busy;
      end
      chps_pkg::OFS_CLK_CTRL: begin
        rdata_d[chps_pkg::CC_INT_EN] = int_clk_en_q;
        rdata_d[chps_pkg::CC_STABLE] = clk_if.int_clk_stable;
        rdata_d[chps_pkg::CC_OUT_ON] = card_clk_output_on_q;
        rdata_d[chps_pkg::CC_DIV_LSB +: chps_pkg::DIV_W] = card_clk_divisor_q;
      end
      chps_pkg::OFS_PWR_CTRL: begin
        rdata_d[chps_pkg::PC_POWER] = bus_power_on_q;
        rdata_d[chps_pkg::PC_VOLT_LSB +: chps_pkg::VOLT_W] = bus_volt_sel_q;
      end
      chps_pkg::OFS_HOST_CTRL: rdata_d[chps_pkg::HC_WIDTH4] = width4_q;
      chps_pkg::OFS_TMO_CTRL: rdata_d[chps_pkg::TMO_W-1:0] = tmo_val_q;
      chps_pkg::OFS_INT_STS: rdata_d[chps_pkg::NUM_EVT-1:0] = sts_q;
      chps_pkg::OFS_INT_STS_EN: rdata_d[chps_pkg::NUM_EVT-1:0] = sts_en_q;
      chps_pkg::OFS_INT_SIG_EN: rdata_d[chps_pkg::NUM_EVT-1:0] = sig_en_q;
      chps_pkg::OFS_CAPS: rdata_d = caps;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // clock control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_clk_en_q <= 1'b0;
      card_clk_output_on_q <= 1'b0;
      card_clk_divisor_q <= chps_pkg::DIV_RST;
    end else if (reg_hit(chps_pkg::OFS_CLK_CTRL)) begin
      logic [31:0] v;
      v = be_merge(32'({card_clk_divisor_q, 5'h0, card_clk_output_on_q, 1'b0, int_clk_en_q}),
                   avs_writedata, avs_byteenable);
      int_clk_en_q <= v[chps_pkg::CC_INT_EN];
      card_clk_output_on_q <= v[chps_pkg::CC_OUT_ON];
      card_clk_divisor_q <= v[chps_pkg::CC_DIV_LSB +: chps_pkg::DIV_W];
    end
  end

  assign clk_if.int_clk_en = int_clk_en_q;
  assign clk_if.card_clk_output_on = card_clk_output_on_q;
  assign clk_if.card_clk_divisor = card_clk_divisor_q;

  chps_clk_gen u_clk_gen (
    .ref_clk (ref_clk),
    .rst (rst),
    .clk_ctl (clk_if.gen)
  );

  // ==========================================================
  // power, width and timeout registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_power_on_q <= 1'b0;
      bus_volt_sel_q <= chps_pkg::VOLT_RST;
    end else if (reg_hit(chps_pkg::OFS_PWR_CTRL) && avs_byteenable[0]) begin
      // voltage and power land in the same write, so one access may do both
      bus_power_on_q <= avs_writedata[chps_pkg::PC_POWER];
      bus_volt_sel_q <= avs_writedata[chps_pkg::PC_VOLT_LSB +: chps_pkg::VOLT_W];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      width4_q <= 1'b0;
    end else if (reg_hit(chps_pkg::OFS_HOST_CTRL) && avs_byteenable[0]) begin
      width4_q <= avs_writedata[chps_pkg::HC_WIDTH4];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmo_val_q <= chps_pkg::TMO_RST;
    end else if (reg_hit(chps_pkg::OFS_TMO_CTRL) && avs_byteenable[0]) begin
      tmo_val_q <= avs_writedata[chps_pkg::TMO_W-1:0];
    end
  end

  // ==========================================================
  // interrupt enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sts_en_q <= chps_pkg::INT_EN_RST;
      sig_en_q <= chps_pkg::INT_EN_RST;
    end else begin
      if (reg_hit(chps_pkg::OFS_INT_STS_EN) && avs_byteenable[0]) begin
        sts_en_q <= avs_writedata[chps_pkg::NUM_EVT-1:0];
      end
      if (reg_hit(chps_pkg::OFS_INT_SIG_EN) && avs_byteenable[0]) begin
        sig_en_q <= avs_writedata[chps_pkg::NUM_EVT-1:0];
      end
    end
  end

  // ==========================================================
  // card presence; first sample after reset is taken as the baseline, no event
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      card_in_q <= 1'b0;
      card_in_seen_q <= 1'b0;
    end else begin
      card_in_q <= ~card_detect_n;
      card_in_seen_q <= 1'b1;
    end
  end

  // ==========================================================
  // data line timeout, counted on ref_clk while a transfer is active
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmo_cnt_q <= '0;
      tmo_hit_q <= 1'b0;
    end else if (!data_active) begin
      tmo_cnt_q <= '0;
      tmo_hit_q <= 1'b0;
    end else if (!tmo_hit_q) begin
      if (tmo_cnt_q == tmo_limit(tmo_val_q) - 1'b1) begin
        tmo_hit_q <= 1'b1;
      end else begin
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
      end
    end
  end

  assign tmo_fire = data_active && !tmo_hit_q && (tmo_cnt_q == tmo_limit(tmo_val_q) - 1'b1);

  // ==========================================================
  // event status: set wins over a write-one clear in the same cycle
  always_comb begin
    evt_set = '0;
    evt_set[chps_pkg::IS_INSERT] = card_in_seen_q && !card_in_q && !card_detect_n;
    evt_set[chps_pkg::IS_REMOVE] = card_in_seen_q && card_in_q && card_detect_n;
    evt_set[chps_pkg::IS_DATA_TMO] = tmo_fire;
    evt_set = evt_set & sts_en_q;
    evt_clr = '0;
    if (reg_hit(chps_pkg::OFS_INT_STS) && avs_byteenable[0]) begin
      evt_clr = avs_writedata[chps_pkg::NUM_EVT-1:0];
    end
    // card interrupt is a level from the card, cleared at the card, not by this register
    evt_clr[chps_pkg::IS_CARD_INT] = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sts_q <= '0;
    end else begin
      sts_q <= (sts_q & ~evt_clr) | evt_set;
      sts_q[chps_pkg::IS_CARD_INT] <= !card_int_n && sts_en_q[chps_pkg::IS_CARD_INT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sts_q & sig_en_q);
    end
  end

  // ==========================================================
  // outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = ~ack_q;
  assign card_clk = clk_if.card_clk;
  assign bus_power_on = bus_power_on_q;
  assign bus_volt_sel = bus_volt_sel_q;
  assign bus_width4 = width4_q;
  assign irq = irq_q;
endmodule

// File: testbench/chps_assertions.sv
// port-level checks of the card host setup block
`timescale 1ns/10ps
module chps_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic avs_read,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // card side
  input wire logic card_detect_n,
  input wire logic card_clk,
  input wire logic bus_power_on,
  input wire logic [chps_pkg::VOLT_W-1:0] bus_volt_sel,
  input wire logic bus_width4,
  input wire logic irq
);
  // ==========
  // shadows of the enables, taken at each accepted write
  logic wr_ok;
  logic [3:0] sts_en_q;
  logic [3:0] sig_en_q;
  logic [2:0] clk_ctl_q;
  logic [8:0] idle_q;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sts_en_q <= 4'h0;
      sig_en_q <= 4'h0;
      clk_ctl_q <= 3'h0;
    end else if (wr_ok) begin
      if (avs_address == chps_pkg::OFS_INT_STS_EN) sts_en_q <= avs_writedata[3:0];
      if (avs_address == chps_pkg::OFS_INT_SIG_EN) sig_en_q <= avs_writedata[3:0];
      if (avs_address == chps_pkg::OFS_CLK_CTRL) clk_ctl_q <= avs_writedata[2:0];
    end
  end
  // cycles without a card clock edge while the clock is meant to run
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) idle_q <= 9'h0;
    else if (!(clk_ctl_q[0] && clk_ctl_q[2]) || $changed(card_clk)) idle_q <= 9'h0;
    else if (idle_q != 9'h1ff) idle_q <= idle_q + 9'h1;
  end
  // ==========
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  reset_vals_a: assert property ($fell(rst) |-> !card_clk && !bus_power_on && !bus_width4 && !irq)
    else $error("outputs wrong after reset");
  insert_irq_a: assert property ($fell(card_detect_n) && sts_en_q[0] && sig_en_q[0] |-> ##[1:3] irq)
    else $error("no irq on insertion");
  remove_irq_a: assert property ($rose(card_detect_n) && sts_en_q[1] && sig_en_q[1] |-> ##[1:3] irq)
    else $error("no irq on removal");
  irq_mask_a: assert property (sig_en_q == 4'h0 && $past(sig_en_q) == 4'h0 |-> !irq)
    else $error("irq without signal enable");
  clk_hold_a: assert property (!clk_ctl_q[2] && !card_clk && !(wr_ok && avs_address == chps_pkg::OFS_CLK_CTRL)
    |=> !card_clk)
    else $error("card clock moved while off");
  clk_runs_a: assert property (clk_ctl_q[0] && clk_ctl_q[2] |-> idle_q < 9'd300)
    else $error("card clock not running");
  pwr_upd_a: assert property (wr_ok && avs_address == chps_pkg::OFS_PWR_CTRL |=>
    bus_power_on == $past(avs_writedata[0]) && bus_volt_sel == $past(avs_writedata[3:1]))
    else $error("power controls not updated");
  pwr_hold_a: assert property (!(wr_ok && avs_address == chps_pkg::OFS_PWR_CTRL) |=>
    $stable(bus_power_on) && $stable(bus_volt_sel))
    else $error("power controls changed unasked");
  width_upd_a: assert property (wr_ok && avs_address == chps_pkg::OFS_HOST_CTRL |=>
    bus_width4 == $past(avs_writedata[1]))
    else $error("width not updated");
endmodule
bind chps_top chps_chk u_chk (.ref_clk, .rst, .avs_address, .avs_write, .avs_read, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .card_detect_n, .card_clk, .bus_power_on, .bus_volt_sel,
  .bus_width4, .irq);

// File: testbench/chps_card_model.sv
// behavioural card in the slot: detect switch and interrupt line
`timescale 1ns/10ps
module chps_card_model (
  // from the host
  input wire logic card_clk,
  input wire logic bus_power_on,
  // bench controls
  input wire logic inserted,
  input wire logic int_req,
  // to the host
  output logic card_detect_n,
  output logic card_int_n,
  output int clk_edges
);
  // the switch has a pull-up, so an empty slot reads high
  assign card_detect_n = !inserted;
  // the model card is never locked and has no function-level interrupt gate, so a width change
  // needs no card-side step; int_req stays low across it
  // it always follows the detect switch, so no silent removal needs a re-initialisation
  // an absent or unpowered card cannot pull its interrupt line low
  assign card_int_n = !(inserted && bus_power_on && int_req);
  // edges seen by the card tell a stopped clock from a slow one
  initial clk_edges = 0;
  always @(posedge card_clk) clk_edges++;
endmodule

// File: testbench/tb.sv
// self-checking bench for the card host setup block
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic cmd_line_busy = 1'b0, data_line_busy = 1'b0, data_active = 1'b0, inserted = 1'b0, int_req = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, card_detect_n, card_int_n, card_clk, bus_power_on, bus_width4, irq, w;
  logic [chps_pkg::VOLT_W-1:0] bus_volt_sel, v;
  logic [7:0] d;
  logic [1:0] b;
  int clk_edges, n, e, n_errors = 0, compares = 0, cyc = 0;
  realtime t0, t1;
  logic [31:0] rst_map [10] = '{32'h0, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    {5'h0, 3'h7, 10'h0, 6'h0a, 1'b1, 1'b0, 6'h0a}, 32'h0};
  chps_top DUT (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .card_detect_n, .card_int_n, .cmd_line_busy, .data_line_busy,
    .data_active, .card_clk, .bus_power_on, .bus_volt_sel, .bus_width4, .irq);
  chps_card_model u_card (.card_clk, .bus_power_on, .inserted, .int_req, .card_detect_n, .card_int_n,
    .clk_edges);
  initial forever #50 ref_clk = ~ref_clk;
  // ==========
  // helpers
  function automatic logic [31:0] clk_exp(input logic [7:0] dv, input logic [2:0] bits);
    return {16'h0, dv, 5'h0, bits};
  endfunction
  function automatic int period(input logic [7:0] dv);
    return (dv == 8'h00) ? 2 : 2 * int'(dv);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr_n;
    avs_read <= !wr_n;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 4'hf);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(what, rd, exp);
  endtask
  task automatic slot(input logic i);
    @(posedge ref_clk) inserted <= i;
    repeat (3) @(posedge ref_clk);
  endtask
  // hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ==========
  // tests
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    void'($urandom(29463));
    foreach (rst_map[i]) rdc("reset value", 8'(4 * i), rst_map[i]);
    wr(chps_pkg::OFS_CAPS, 32'hffffffff);
    wr(8'h24, 32'hffffffff);
    rdc("caps read only", chps_pkg::OFS_CAPS, rst_map[8]);
    rdc("unmapped", 8'h24, 32'h0);
    $display("test registers done");
    wr(chps_pkg::OFS_INT_STS_EN, 32'h7);
    wr(chps_pkg::OFS_INT_SIG_EN, 32'h3);
    slot(1'b1);
    chk("irq insert", irq, 1'b1);
    rdc("present", chps_pkg::OFS_PRESENT, 32'h1);
    rdc("insert event", chps_pkg::OFS_INT_STS, 32'h1);
    wr(chps_pkg::OFS_INT_STS, 32'h1);
    rdc("insert cleared", chps_pkg::OFS_INT_STS, 32'h0);
    chk("irq cleared", irq, 1'b0);
    wr(chps_pkg::OFS_PWR_CTRL, 32'hf);
    @(posedge ref_clk) int_req <= 1'b1;
    rdc("card int", chps_pkg::OFS_INT_STS, 32'h4);
    chk("card int unsignalled", irq, 1'b0);
    wr(chps_pkg::OFS_INT_STS_EN, 32'h3);
    rdc("card int masked", chps_pkg::OFS_INT_STS, 32'h0);
    @(posedge ref_clk) int_req <= 1'b0;
    slot(1'b0);
    chk("irq removal", irq, 1'b1);
    rdc("removal event", chps_pkg::OFS_INT_STS, 32'h2);
    rdc("absent", chps_pkg::OFS_PRESENT, 32'h0);
    wr(chps_pkg::OFS_INT_STS, 32'h2);
    wr(chps_pkg::OFS_INT_STS_EN, 32'h0);
    slot(1'b1);
    rdc("event dropped", chps_pkg::OFS_INT_STS, 32'h0);
    wr(chps_pkg::OFS_INT_STS_EN, 32'h3);
    wr(chps_pkg::OFS_INT_SIG_EN, 32'h0);
    slot(1'b0);
    rdc("event unsignalled", chps_pkg::OFS_INT_STS, 32'h2);
    chk("irq masked", irq, 1'b0);
    wr(chps_pkg::OFS_INT_STS, 32'h2);
    wr(chps_pkg::OFS_INT_STS_EN, 32'h0);
    slot(1'b1);
    $display("test detection done");
    repeat (6) begin
      b = 2'($urandom);
      @(posedge ref_clk);
      cmd_line_busy <= b[0];
      data_line_busy <= b[1];
      repeat (3) @(posedge ref_clk);
      rdc("busy flags", chps_pkg::OFS_PRESENT, {29'h0, b, 1'b1});
    end
    cmd_line_busy <= 1'b0;
    data_line_busy <= 1'b0;
    $display("test busy flags done");
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 8'h00 : 8'($urandom_range(1, 6));
      wr(chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h1));
      rdc("not yet stable", chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h1));
      n = 0;
      do begin
        bus(1'b0, chps_pkg::OFS_CLK_CTRL, 32'h0, 4'hf);
        n++;
      end while (rd[1] !== 1'b1 && n < 20);
      chk("stable", rd, clk_exp(d, 3'h3));
      e = clk_edges;
      repeat (20) @(posedge ref_clk);
      chk("clock held", clk_edges, e);
      wr(chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h5));
      @(posedge card_clk) t0 = $realtime;
      @(posedge card_clk) t1 = $realtime;
      chk("card clock period", int'((t1 - t0) / 100.0), period(d));
      wr(chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h1));
      repeat (period(d) + 4) @(posedge ref_clk);
      e = clk_edges;
      repeat (30) @(posedge ref_clk);
      chk("clock stopped", clk_edges, e);
      chk("clock low", card_clk, 1'b0);
      // internal clock off too, so the next pass sees stable rise again
      wr(chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h0));
    end
    bus(1'b1, chps_pkg::OFS_CLK_CTRL, 32'h0000ff00, 4'h1);
    rdc("divisor kept", chps_pkg::OFS_CLK_CTRL, clk_exp(d, 3'h0));
    $display("test card clock done");
    repeat (4) begin
      v = 3'($urandom);
      w = 1'($urandom);
      wr(chps_pkg::OFS_INT_STS_EN, 32'h0);
      wr(chps_pkg::OFS_PWR_CTRL, 32'h0);
      wr(chps_pkg::OFS_PWR_CTRL, {28'h0, v, 1'b1});
      wr(chps_pkg::OFS_HOST_CTRL, {30'h0, w, 1'b0});
      wr(chps_pkg::OFS_INT_STS_EN, 32'h4);
      chk("bus pins", {bus_width4, bus_volt_sel, bus_power_on}, {w, v, 1'b1});
      rdc("power reg", chps_pkg::OFS_PWR_CTRL, {28'h0, v, 1'b1});
      rdc("width reg", chps_pkg::OFS_HOST_CTRL, {30'h0, w, 1'b0});
    end
    $display("test power and width done");
    wr(chps_pkg::OFS_INT_STS_EN, 32'h8);
    wr(chps_pkg::OFS_TMO_CTRL, 32'h0);
    @(posedge ref_clk) data_active <= 1'b1;
    repeat (8150) @(posedge ref_clk);
    rdc("no timeout yet", chps_pkg::OFS_INT_STS, 32'h0);
    repeat (60) @(posedge ref_clk);
    rdc("data timeout", chps_pkg::OFS_INT_STS, 32'h8);
    data_active <= 1'b0;
    $display("test data timeout done");
    tally_and_finish();
  end
endmodule
